// file: slsf_map.svh
/*
 holds register offsets, field positions and timing counts of the link status block.
 assumes inclusion by bare name from the package and design files.
*/
`ifndef SLSF_MAP_SVH
`define SLSF_MAP_SVH
`define SLSF_STATUS_IDX 16'h006c
`define SLSF_STATUS_ADDR 18'h001b0
`define SLSF_BIT_CLK_PRESENT 0
`define SLSF_BIT_CAL_DONE 1
`define SLSF_BIT_PLL_LOCK 2
`define SLSF_BIT_ALIGN 3
`define SLSF_BIT_SYSREF_PHASE_SHIFT_FLAG 4
`define SLSF_BIT_SYNC_IDLE 5
`define SLSF_BIT_LINK_UP 6
`define SLSF_STATUS_RESET 8'h20
`define SLSF_SYNC_HOLD_FRAMES 4
`endif

// file: slsf_pkg.sv
/*
 types of the link status block.
 assumes slsf_map.svh alongside.
*/
`include "slsf_map.svh"
package slsf_pkg;
    typedef enum logic [1:0] {SLSF_IDLE, SLSF_HOLD, SLSF_SYNCING} slsf_sync_t;
    typedef struct packed {
        slsf_sync_t sync_st;
        logic [2:0] hold_cnt;
        logic sysref_phase_shift_flag;
        logic align;
        logic sysref_d;
        logic clk_present_d;
        logic link_up;
        logic [7:0] rdata;
        logic rvalid;
        logic err;
    } slsf_state_t;
endpackage

// file: slsf_status.sv
/*
 link status flag register behind an avalon-mm slave with waitrequest.
 assumes all status inputs synchronous to mclk; frame_tick pulses once per local frame clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "slsf_map.svh"
module slsf_status
    import slsf_pkg::*;
#(
    parameter int HOLD_FRAMES = `SLSF_SYNC_HOLD_FRAMES
) (
    input wire logic mclk, // system clock
    input wire logic rst, // sync reset, active high
    input wire logic ce, // clock enable
    input wire logic [17:0] avs_address, // byte address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output logic [1:0] avs_response, // 00 ok, 10 slave error
    input wire logic resync_request_input_n, // receiver sync request, low active
    input wire logic frame_tick, // one pulse per local frame clock
    input wire logic ila_done, // lane alignment sequence sent
    input wire logic data_valid, // sample data transmitted
    input wire logic sysref_in, // sysref level after detection enable
    input wire logic sysref_phase_shift, // sysref moved frame or lmfc phase
    input wire logic pll_locked, // pll lock
    input wire logic cal_done, // calibration complete
    input wire logic clk_present, // sample_clock_input active
    output logic sync_active // sync sequence running
);
    import slsf_pkg::*;

    slsf_state_t s_r, s_nxt;
    logic hit, wr_acc, rd_acc, sysref_rise, clk_fall, clr_sysref_phase_shift_flag, clr_align;
    logic [7:0] status;

    assign hit = (avs_address == `SLSF_STATUS_ADDR);
    assign wr_acc = avs_write && !s_r.rvalid;
    assign rd_acc = avs_read && !s_r.rvalid;
    assign sysref_rise = sysref_in && !s_r.sysref_d;
    assign clk_fall = s_r.clk_present_d && !clk_present;
    // write-one clears only byte lane 0; zeros do nothing
    assign clr_sysref_phase_shift_flag = wr_acc && hit && avs_byteenable[0]
        && avs_writedata[`SLSF_BIT_SYSREF_PHASE_SHIFT_FLAG];
    assign clr_align = wr_acc && hit && avs_byteenable[0]
        && avs_writedata[`SLSF_BIT_ALIGN];

    always_comb begin
        status = 8'h00;
        status[`SLSF_BIT_LINK_UP] = s_r.link_up;
        status[`SLSF_BIT_SYNC_IDLE] = (s_r.sync_st == SLSF_IDLE);
        status[`SLSF_BIT_SYSREF_PHASE_SHIFT_FLAG] = s_r.sysref_phase_shift_flag;
        status[`SLSF_BIT_ALIGN] = s_r.align;
        status[`SLSF_BIT_PLL_LOCK] = pll_locked;
        status[`SLSF_BIT_CAL_DONE] = cal_done;
        status[`SLSF_BIT_CLK_PRESENT] = clk_present;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.sysref_d = sysref_in;
        s_nxt.clk_present_d = clk_present;
        // sync sequencing: request must persist for the hold before syncing
        case (s_r.sync_st)
            SLSF_IDLE: begin
                s_nxt.hold_cnt = 3'h0;
                if (!resync_request_input_n) begin
                    s_nxt.sync_st = SLSF_HOLD;
                end
            end
            SLSF_HOLD: begin
                if (resync_request_input_n) begin
                    s_nxt.sync_st = SLSF_IDLE;
                end else if (frame_tick) begin
                    if (32'(s_r.hold_cnt) + 32'd1 >= HOLD_FRAMES) begin
                        s_nxt.sync_st = SLSF_SYNCING;
                    end else begin
                        s_nxt.hold_cnt = s_r.hold_cnt + 3'h1;
                    end
                end
            end
            SLSF_SYNCING: begin
                // ends once the receiver releases its request
                if (resync_request_input_n) begin
                    s_nxt.sync_st = SLSF_IDLE;
                end
            end
            default: s_nxt.sync_st = SLSF_IDLE;
        endcase
        s_nxt.link_up = (s_r.sync_st == SLSF_IDLE) && resync_request_input_n
            && ila_done && data_valid;
        // sticky flags: set beats clear, clock loss beats all
        if (clr_sysref_phase_shift_flag) begin
            s_nxt.sysref_phase_shift_flag = 1'b0;
        end
        if (sysref_rise && sysref_phase_shift) begin
            s_nxt.sysref_phase_shift_flag = 1'b1;
        end
        if (clr_align) begin
            s_nxt.align = 1'b0;
        end
        if (sysref_rise) begin
            s_nxt.align = 1'b1;
        end
        if (clk_fall) begin
            s_nxt.sysref_phase_shift_flag = 1'b0;
            s_nxt.align = 1'b0;
        end
        // one-wait-state bus: request taken, answer valid next cycle
        s_nxt.rvalid = 1'b0;
        s_nxt.rdata = 8'h00;
        s_nxt.err = 1'b0;
        if (rd_acc || wr_acc) begin
            s_nxt.rvalid = 1'b1;
            // unmapped addresses still answer, with slave error
            s_nxt.err = !hit;
            if (rd_acc && hit) begin
                s_nxt.rdata = status;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
            s_r.sync_st <= SLSF_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !s_r.rvalid;
    assign avs_readdata = {24'h000000, s_r.rdata};
    assign avs_response = s_r.err ? 2'b10 : 2'b00;
    assign sync_active = (s_r.sync_st == SLSF_SYNCING);

    property p_sync_hold;
        @(posedge mclk) disable iff (rst)
        (s_r.sync_st == SLSF_HOLD) && ce && resync_request_input_n
            |=> s_r.sync_st == SLSF_IDLE;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync not abandoned");

    property p_idle_flag;
        @(posedge mclk) disable iff (rst)
        ce && !resync_request_input_n |=> !status[`SLSF_BIT_SYNC_IDLE];
    endproperty
    a_idle_flag: assert property (p_idle_flag) else $error("sync idle while syncing");

    property p_link;
        @(posedge mclk) disable iff (rst)
        ce && !(ila_done && data_valid) |=> !s_r.link_up;
    endproperty
    a_link: assert property (p_link) else $error("link up without data");

    property p_align_set;
        @(posedge mclk) disable iff (rst)
        ce && sysref_rise && !clk_fall |=> s_r.align;
    endproperty
    a_align_set: assert property (p_align_set) else $error("align not set");

    property p_sysref_phase_shift_flag_set;
        @(posedge mclk) disable iff (rst)
        ce && sysref_rise && sysref_phase_shift && !clk_fall |=> s_r.sysref_phase_shift_flag;
    endproperty
    a_sysref_phase_shift_flag_set: assert property (p_sysref_phase_shift_flag_set) else $error("sysref_phase_shift_flag not set");

    property p_sysref_phase_shift_flag_hold;
        @(posedge mclk) disable iff (rst)
        ce && !(sysref_rise && sysref_phase_shift) && !clr_sysref_phase_shift_flag && !clk_fall
            |=> s_r.sysref_phase_shift_flag == $past(s_r.sysref_phase_shift_flag);
    endproperty
    a_sysref_phase_shift_flag_hold: assert property (p_sysref_phase_shift_flag_hold) else $error("sysref_phase_shift_flag moved");

    property p_clear;
        @(posedge mclk) disable iff (rst)
        ce && clr_align && !sysref_rise |=> !s_r.align;
    endproperty
    a_clear: assert property (p_clear) else $error("align not cleared");

    property p_clk_loss;
        @(posedge mclk) disable iff (rst)
        ce && clk_fall |=> !s_r.align && !s_r.sysref_phase_shift_flag;
    endproperty
    a_clk_loss: assert property (p_clk_loss) else $error("flags kept on clock loss");

    property p_bus_answer;
        @(posedge mclk) disable iff (rst)
        ce && avs_read && avs_waitrequest |=> !avs_waitrequest || !ce;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("read not answered");

    property p_idle_return;
        @(posedge mclk) disable iff (rst)
        ce && resync_request_input_n |=> status[`SLSF_BIT_SYNC_IDLE];
    endproperty
    a_idle_return: assert property (p_idle_return) else $error("idle not back");

    property p_link_sync;
        @(posedge mclk) disable iff (rst)
        ce && (s_r.sync_st != SLSF_IDLE) |=> !s_r.link_up;
    endproperty
    a_link_sync: assert property (p_link_sync) else $error("link up in sync");

    property p_no_early_sync;
        @(posedge mclk) disable iff (rst)
        ce && (s_r.sync_st == SLSF_IDLE) |=> !sync_active;
    endproperty
    a_no_early_sync: assert property (p_no_early_sync) else $error("early sync");

    // read answers carry the live inputs as they stood at acceptance
    property p_pll_bit;
        @(posedge mclk) disable iff (rst)
        ce && rd_acc && hit |=> avs_readdata[`SLSF_BIT_PLL_LOCK] == $past(pll_locked);
    endproperty
    a_pll_bit: assert property (p_pll_bit) else $error("pll bit wrong");

    property p_cal_bit;
        @(posedge mclk) disable iff (rst)
        ce && rd_acc && hit |=> avs_readdata[`SLSF_BIT_CAL_DONE] == $past(cal_done);
    endproperty
    a_cal_bit: assert property (p_cal_bit) else $error("cal bit wrong");

    property p_clk_bit;
        @(posedge mclk) disable iff (rst)
        ce && rd_acc && hit |=> avs_readdata[`SLSF_BIT_CLK_PRESENT] == $past(clk_present);
    endproperty
    a_clk_bit: assert property (p_clk_bit) else $error("clock bit wrong");

    property p_unmapped;
        @(posedge mclk) disable iff (rst)
        ce && (rd_acc || wr_acc) && !hit
            |=> avs_response == 2'b10 && avs_readdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slave error");

    property p_rd_ok;
        @(posedge mclk) disable iff (rst)
        ce && rd_acc && hit |=> avs_response == 2'b00;
    endproperty
    a_rd_ok: assert property (p_rd_ok) else $error("bad response");

    property p_align_wr_zero;
        @(posedge mclk) disable iff (rst)
        ce && wr_acc && hit && !avs_writedata[`SLSF_BIT_ALIGN] && s_r.align && !clk_fall
            |=> s_r.align;
    endproperty
    a_align_wr_zero: assert property (p_align_wr_zero) else $error("align lost");

    property p_sysref_phase_shift_flag_wr_zero;
        @(posedge mclk) disable iff (rst)
        ce && wr_acc && hit && !avs_writedata[`SLSF_BIT_SYSREF_PHASE_SHIFT_FLAG] && s_r.sysref_phase_shift_flag && !clk_fall
            |=> s_r.sysref_phase_shift_flag;
    endproperty
    a_sysref_phase_shift_flag_wr_zero: assert property (p_sysref_phase_shift_flag_wr_zero) else $error("sysref_phase_shift_flag lost");

    property p_sysref_phase_shift_flag_clear;
        @(posedge mclk) disable iff (rst)
        ce && clr_sysref_phase_shift_flag && !(sysref_rise && sysref_phase_shift) |=> !s_r.sysref_phase_shift_flag;
    endproperty
    a_sysref_phase_shift_flag_clear: assert property (p_sysref_phase_shift_flag_clear) else $error("sysref_phase_shift_flag kept");

    property p_align_hold;
        @(posedge mclk) disable iff (rst)
        ce && !sysref_rise && !clr_align && !clk_fall
            |=> s_r.align == $past(s_r.align);
    endproperty
    a_align_hold: assert property (p_align_hold) else $error("align moved");

    // the enable gates every state bit, bus handshake included
    property p_freeze;
        @(posedge mclk) disable iff (rst)
        !ce |=> s_r == $past(s_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    c_sync: cover property (@(posedge mclk) disable iff (rst) sync_active);
    c_link: cover property (@(posedge mclk) disable iff (rst) s_r.link_up);
    c_align: cover property (@(posedge mclk) disable iff (rst) clr_align ##1 !s_r.align);
    c_sysref_phase_shift_flag: cover property (@(posedge mclk) disable iff (rst) s_r.sysref_phase_shift_flag ##1 !s_r.sysref_phase_shift_flag);
    c_slave_err: cover property (@(posedge mclk) disable iff (rst) avs_response == 2'b10);
endmodule
`default_nettype wire

// file: slsf_rx_model.sv
/*
 far-side receiver model driving the low-active sync request.
 assumes frame_tick from the bench, one pulse per frame clock.
*/
`timescale 1ns/10ps
`default_nettype none
module slsf_rx_model (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic frame_tick, // frame pulse
    input wire logic want_sync, // bench asks for sync
    output logic sync_n // sync request, low active
);
    logic [2:0] held_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_n <= 1'b1;
            held_r <= 3'h0;
        end else if (want_sync) begin
            sync_n <= 1'b0;
            if (frame_tick && held_r != 3'h7) begin
                held_r <= held_r + 3'h1;
            end
        end else if (held_r >= 3'h4) begin // no release before four frames
            sync_n <= 1'b1;
            held_r <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// file: serial_link_status_flags_tb.sv
/*
 self-checking bench of the link status block.
 assumes slsf_rx_model as the receiver on the sync request.
*/
`timescale 1ns/10ps
`default_nettype none
`include "slsf_map.svh"
module serial_link_status_flags_tb;
    import slsf_pkg::*;
    logic mclk, rst, rd, wr, ft, ila, dv, sr, ps, pll, cal, clk, want, sync_n, wrq, act, al, ra;
    logic en;
    logic [17:0] adr;
    logic [31:0] wd, q, rdat;
    logic [1:0] rsp, resp;
    int fail_count = 0, samples_checked = 0, cyc = 0, seed = 32'h82e9;
    slsf_status uut (.mclk(mclk), .rst(rst), .ce(en), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wrq), .avs_response(resp), .resync_request_input_n(sync_n),
        .frame_tick(ft), .ila_done(ila), .data_valid(dv), .sysref_in(sr),
        .sysref_phase_shift(ps), .pll_locked(pll), .cal_done(cal), .clk_present(clk),
        .sync_active(act));
    slsf_rx_model rx (.mclk(mclk), .rst(rst), .frame_tick(ft), .want_sync(want),
        .sync_n(sync_n));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // request held until waitrequest seen low; data taken at that edge
    task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d);
        @(posedge mclk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        do @(posedge mclk); while (wrq !== 1'b0);
        q = rdat;
        rsp = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    function automatic logic [31:0] ex(input logic lk, idle);
        return {25'h0, lk, idle, ra, al, pll, cal, clk};
    endfunction
    task automatic rchk(input string n, input logic lk, idle);
        acc(1'b0, `SLSF_STATUS_ADDR, 8'h00);
        chk(n, q, ex(lk, idle));
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            ft <= 1'b1;
            @(posedge mclk);
            ft <= 1'b0;
        end
    endtask
    task automatic sref(input logic s);
        @(posedge mclk);
        sr <= 1'b1;
        ps <= s;
        repeat (2) @(posedge mclk);
        sr <= 1'b0;
        ps <= 1'b0;
        al = 1'b1;
        ra = ra | s;
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {rst, rd, wr, ft, ila, dv, sr, ps, pll, cal, clk, want, al, ra} = 14'h2000;
        adr = 18'h0;
        wd = 32'h0;
        en = 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rchk("reset", 1'b0, 1'b1);
        acc(1'b0, 18'h001b4, 8'h00);
        chk("unmapped", {rsp, q[29:0]}, 32'h8000_0000);
        repeat (6) begin
            @(posedge mclk);
            {pll, cal, clk} <= 3'($random(seed));
            rchk("live", 1'b0, 1'b1);
        end
        $display("test map done");
        want <= 1'b1;
        // frames count only once the request is seen low
        repeat (2) @(posedge mclk);
        tick(3);
        chk("hold", {31'h0, act}, 32'h0);
        rchk("hold", 1'b0, 1'b0);
        tick(1);
        repeat (2) @(posedge mclk);
        chk("sync", {31'h0, act}, 32'h1);
        ila <= 1'b1;
        dv <= 1'b1;
        rchk("syncing", 1'b0, 1'b0);
        want <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("idle", {31'h0, act}, 32'h0);
        rchk("link", 1'b1, 1'b1);
        dv <= 1'b0;
        rchk("nodata", 1'b0, 1'b1);
        $display("test sync done");
        cal <= 1'b1; // sysref only once calibration reads done
        clk <= 1'b1;
        sref(1'b0);
        rchk("align", 1'b0, 1'b1);
        sref(1'b1);
        rchk("sysref_phase_shift_flag", 1'b0, 1'b1);
        acc(1'b1, `SLSF_STATUS_ADDR, 8'h00);
        rchk("wr_zero", 1'b0, 1'b1);
        acc(1'b1, `SLSF_STATUS_ADDR, 8'he7);
        rchk("wr_ro", 1'b0, 1'b1);
        acc(1'b1, `SLSF_STATUS_ADDR, 8'h08);
        al = 1'b0;
        rchk("clr_align", 1'b0, 1'b1);
        acc(1'b1, `SLSF_STATUS_ADDR, 8'h10);
        ra = 1'b0;
        rchk("clr_sysref_phase_shift_flag", 1'b0, 1'b1);
        en <= 1'b0; // frozen core must miss this sysref
        sref(1'b1);
        en <= 1'b1;
        al = 1'b0;
        ra = 1'b0;
        rchk("freeze", 1'b0, 1'b1);
        sref(1'b1);
        clk <= 1'b0;
        al = 1'b0;
        ra = 1'b0;
        repeat (2) @(posedge mclk);
        clk <= 1'b1;
        rchk("clk_loss", 1'b0, 1'b1);
        $display("test sysref done");
        stop_test();
    end
endmodule
`default_nettype wire
